// ===== hw/timer_mode_irq_regs.sv
// APB register block for the dual timer mode control and interrupt flags
`timescale 1ns/1ps
`default_nettype none
module timer_mode_irq_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_pin_first,
  input wire logic timer_pin_second,
  output logic timer_pin_first_out,
  output logic timer_pin_first_oe,
  input wire logic first_underflow,
  input wire logic second_underflow,
  input wire logic first_reload_a,
  input wire logic first_reload_b,
  input wire logic second_reload_b,
  input wire logic [15:0] first_counter,
  input wire logic [15:0] second_counter,
  input wire logic accumulate_mode,
  output logic first_counter_preset,
  output logic second_counter_preset,
  output logic [15:0] preset_data,
  output logic accumulate_gate,
  output logic [1:0] operating_mode_select,
  output logic [15:0] reload_capture_first,
  output logic [15:0] reload_capture_second,
  output logic timer_irq_first,
  output logic timer_irq_second
);
  // ****************************************
  // Register state
  // ****************************************
  logic [15:0] reload_first_reg;
  logic [15:0] reload_second_reg;
  logic [7:0] mode_control_reg;
  logic [7:0] mode_control_next;
  logic [3:0] enable_reg;
  logic [3:0] pending;
  logic [3:0] hw_set;
  logic [3:0] sw_set;
  logic [3:0] sw_clear;
  logic a_edge;
  logic b_edge;
  logic b_level;
  // ****************************************
  // Bus decode
  // ****************************************
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire hit_rf = paddr == timer_regs_pkg::reload_first_off;
  wire hit_rs = paddr == timer_regs_pkg::reload_second_off;
  wire hit_mc = paddr == timer_regs_pkg::mode_control_off;
  wire hit_ic = paddr == timer_regs_pkg::irq_ctl_off;
  wire hit_cl = paddr == timer_regs_pkg::irq_clear_off;
  wire mapped = hit_rf | hit_rs | hit_mc | hit_ic | hit_cl;
  wire wr_rf = wr & hit_rf;
  wire wr_rs = wr & hit_rs;
  wire wr_mc = wr & hit_mc & pstrb[0];
  wire wr_ic = wr & hit_ic & pstrb[0];
  wire wr_cl = wr & hit_cl & pstrb[0];
  // Zero-wait slave; unmapped addresses error out and writes are dropped
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  // ****************************************
  // Mode fields
  // ****************************************
  wire [1:0] mode_field = mode_control_reg[timer_regs_pkg::mode_lsb +: 2];
  wire a_rising = mode_control_reg[timer_regs_pkg::a_edge_bit];
  wire b_rising = mode_control_reg[timer_regs_pkg::b_edge_bit];
  wire a_enable = mode_control_reg[timer_regs_pkg::a_en_bit];
  wire b_enable = mode_control_reg[timer_regs_pkg::b_en_bit];
  wire a_level = mode_control_reg[timer_regs_pkg::a_out_bit];
  wire is_dual_cap = mode_field == 2'(timer_regs_pkg::mode_dual_capture);
  wire is_single_cap = mode_field == 2'(timer_regs_pkg::mode_single_capture);
  // Second pin only captures in the two capture modes
  wire b_capture_mode = is_dual_cap | is_single_cap;
  // First pin drives PWM only when enabled and not a capture input
  wire a_is_pwm = a_enable & ~is_dual_cap;
  // ****************************************
  // Pin edge detection
  // ****************************************
  edge_sense pin_a_sense (
    .clk(clk),
    .rst_b(rst_b),
    .pin(timer_pin_first),
    .rising_sel(a_rising),
    .edge_seen(a_edge),
    .level_active()
  );
  edge_sense pin_b_sense (
    .clk(clk),
    .rst_b(rst_b),
    .pin(timer_pin_second),
    .rising_sel(b_rising),
    .edge_seen(b_edge),
    .level_active(b_level)
  );
  // Second-pin captures load in both capture modes, first-pin captures in dual capture only; presets need the pin enable
  wire cap_a = is_dual_cap & a_edge;
  wire cap_b = b_capture_mode & b_edge;
  assign first_counter_preset = cap_a & a_enable | is_dual_cap & b_edge & b_enable;
  assign second_counter_preset = is_single_cap & b_edge & b_enable;
  assign preset_data = timer_regs_pkg::preset_value;
  // Accumulate counting runs only while the pin is at its active level
  assign accumulate_gate = ~accumulate_mode | b_level;
  // ****************************************
  // Reload and capture words
  // ****************************************
  // No reset here: contents survive reset as the timer expects
  always_ff @(posedge clk) begin
    if (wr_rf) begin
      reload_first_reg <= pwdata[15:0];
    end else if (cap_a) begin
      reload_first_reg <= first_counter;
    end
  end
  // Second pin capture takes first counter in dual mode, second in single
  always_ff @(posedge clk) begin
    if (wr_rs) begin
      reload_second_reg <= pwdata[15:0];
    end else if (cap_b) begin
      reload_second_reg <= is_dual_cap ? first_counter : second_counter;
    end
  end
  // ****************************************
  // Mode control with output-data bit
  // ****************************************
  // Software write wins; otherwise hardware toggles the level on underflow while the first pin is a PWM output
  wire [7:0] hw_mode = {mode_control_reg[7], a_level ^ (a_is_pwm & first_underflow), mode_control_reg[5:0]};
  assign mode_control_next = wr_mc ? (pwdata[7:0] & timer_regs_pkg::mode_control_wmask) : hw_mode;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode_control_reg <= timer_regs_pkg::mode_control_rst;
    end else begin
      mode_control_reg <= mode_control_next;
    end
  end
  // Level is only driven when the pin is a PWM output
  assign timer_pin_first_out = a_is_pwm & a_level;
  assign timer_pin_first_oe = a_is_pwm;
  // ****************************************
  // Interrupt enables and pending flags
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      enable_reg <= timer_regs_pkg::irq_ctl_rst[7:4];
    end else if (wr_ic) begin
      enable_reg <= pwdata[7:4];
    end
  end
  // Mode-dependent sources, bit order D C B A
  wire src_a = is_dual_cap ? cap_a : first_reload_a;
  wire src_b = (mode_field == 2'(timer_regs_pkg::mode_pwm)) ? first_reload_b : cap_b;
  wire src_c = is_dual_cap & first_underflow;
  wire is_dual_cnt = mode_field == 2'(timer_regs_pkg::mode_dual_counter);
  wire src_d = is_dual_cnt ? second_reload_b : second_underflow;
  assign hw_set = {src_d, src_c, src_b & ~is_dual_cnt, src_a};
  assign sw_set = wr_ic ? pwdata[3:0] : 4'h0;
  assign sw_clear = wr_cl ? pwdata[3:0] : 4'h0;
  pending_flags #(
    .width(4)
  ) flags (
    .clk(clk),
    .rst_b(rst_b),
    .hw_set(hw_set),
    .sw_set(sw_set),
    .sw_clear(sw_clear),
    .pending(pending)
  );
  // Enable only gates the request, never the flag
  wire [3:0] active = pending & enable_reg;
  assign timer_irq_first = |active[2:0];
  assign timer_irq_second = active[3];
  // ****************************************
  // Read mux
  // ****************************************
  // Clear register is write-only and reads as zero
  wire [31:0] rd_value = hit_rf ? {16'h0000, reload_first_reg} :
                         hit_rs ? {16'h0000, reload_second_reg} :
                         hit_mc ? {24'h000000, mode_control_reg} :
                         hit_ic ? {24'h000000, enable_reg, pending} : 32'h00000000;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rd_value;
    end
  end
  assign operating_mode_select = mode_field;
  assign reload_capture_first = reload_first_reg;
  assign reload_capture_second = reload_second_reg;
  // ****************************************
  // Checks
  // ****************************************
  mode_reset_a: assert property (@(posedge clk) !rst_b |=> mode_control_reg == 8'h00) else $error("mode not cleared");
  sw_wins_a: assert property (@(posedge clk) disable iff (!rst_b) wr_mc |=> a_level == $past(pwdata[6])) else $error("software write lost");
  pwm_toggle_a: assert property (@(posedge clk) disable iff (!rst_b) (a_is_pwm && first_underflow && !wr_mc) |=> a_level != $past(a_level)) else $error("no toggle");
  pin_idle_a: assert property (@(posedge clk) disable iff (!rst_b) !a_is_pwm |-> !timer_pin_first_oe && !timer_pin_first_out) else $error("pin driven as input");
  b_ignored_a: assert property (@(posedge clk) disable iff (!rst_b) !b_capture_mode |-> !second_counter_preset) else $error("b preset in timer mode");
  clear_one_a: assert property (@(posedge clk) disable iff (!rst_b) (wr_cl && pwdata[0] && !hw_set[0]) |=> !pending[0]) else $error("clear failed");
  zero_ignored_a: assert property (@(posedge clk) disable iff (!rst_b) (wr_ic && !wr_cl && pending[1]) |=> pending[1]) else $error("zero write cleared");
  irq_map_a: assert property (@(posedge clk) disable iff (!rst_b) timer_irq_second == (pending[3] && enable_reg[3])) else $error("second irq map");
  irq_first_a: assert property (@(posedge clk) disable iff (!rst_b) (pending[0] && enable_reg[0]) |-> timer_irq_first) else $error("first irq missing");
endmodule
`default_nettype wire

// ===== hw/timer_regs_pkg.sv
// Constants for the dual timer mode and interrupt register block
package timer_regs_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] reload_first_off = 12'h000;
  localparam logic [11:0] reload_second_off = 12'h004;
  localparam logic [11:0] mode_control_off = 12'h008;
  localparam logic [11:0] irq_ctl_off = 12'h00c;
  localparam logic [11:0] irq_clear_off = 12'h010;
  // ****************************************
  // Mode control fields
  // ****************************************
  localparam int mode_lsb = 0;
  localparam int a_edge_bit = 2;
  localparam int b_edge_bit = 3;
  localparam int a_en_bit = 4;
  localparam int b_en_bit = 5;
  localparam int a_out_bit = 6;
  localparam logic [7:0] mode_control_rst = 8'h00;
  localparam logic [7:0] mode_control_wmask = 8'h7f;
  localparam logic [7:0] irq_ctl_rst = 8'h00;
  localparam logic [15:0] preset_value = 16'hffff;
  typedef enum logic [1:0] {mode_pwm, mode_dual_capture, mode_dual_counter, mode_single_capture} timer_mode_t;
endpackage

// ===== hw/edge_sense.sv
// Pin synchroniser with polarity-selected edge detect and level qualify
`timescale 1ns/1ps
`default_nettype none
module edge_sense (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pin,
  input wire logic rising_sel,
  output logic edge_seen,
  output logic level_active
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;
  // ****************************************
  // Two-stage synchroniser, then history
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end
  // Polarity picks rising or falling edge; level used for accumulate gating
  assign edge_seen = rising_sel ? (sync_reg & ~prev_reg) : (~sync_reg & prev_reg);
  assign level_active = rising_sel ? sync_reg : ~sync_reg;
endmodule
`default_nettype wire

// ===== hw/pending_flags.sv
// Four sticky pending flags with set, software set and write-one clear
`timescale 1ns/1ps
`default_nettype none
module pending_flags #(
  parameter int width = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [width-1:0] hw_set,
  input wire logic [width-1:0] sw_set,
  input wire logic [width-1:0] sw_clear,
  output logic [width-1:0] pending
);
  logic [width-1:0] pending_reg;
  logic [width-1:0] pending_next;
  initial begin
    if (width < 1) $error("pending_flags width must be positive");
  end
  // Set beats clear so an event in the clearing cycle is kept
  assign pending_next = (pending_reg & ~sw_clear) | hw_set | sw_set;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pending_reg <= '0;
    end else begin
      pending_reg <= pending_next;
    end
  end
  assign pending = pending_reg;
  set_wins_a: assert property (@(posedge clk) disable iff (!rst_b) (|hw_set) |=> ((pending & $past(hw_set)) == $past(hw_set))) else $error("hardware set lost");
endmodule
`default_nettype wire

// ===== verification/far_side_model.sv
// Far-side model: counter datapath events and counter values
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
  input wire logic clk,
  input wire logic [4:0] ev_req,
  input wire logic ld,
  input wire logic [15:0] c1_req,
  input wire logic [15:0] c2_req,
  input wire logic pre1,
  input wire logic pre2,
  input wire logic [15:0] pdata,
  output logic [4:0] ev,
  output logic [15:0] c1,
  output logic [15:0] c2
);
  // Known levels before the first edge
  initial begin
    ev = 5'h00;
    c1 = 16'h0000;
    c2 = 16'h0000;
  end
  // A preset wins over a load, as in the real counters; events are one-cycle pulses
  always @(posedge clk) begin
    ev <= ev_req;
    if (pre1) c1 <= pdata;
    else if (ld) c1 <= c1_req;
    if (pre2) c2 <= pdata;
    else if (ld) c2 <= c2_req;
  end
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the timer mode and interrupt register block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rst_b, psel, penable, pwrite, pin1, pin2, ld, acc, e;
  logic pready, pslverr, aout, aoe, pre1, pre2, gate, irq1, irq2;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, v1, v2, d;
  logic [3:0] pstrb;
  logic [4:0] ev_req, ev;
  logic [15:0] c1_req, c2_req, c1, c2, pdata, rl1, rl2;
  logic [1:0] msel;
  int err_count, n_compared, cyc, n_pre1, n_pre2, m;
  localparam logic [11:0] a_rl1 = timer_regs_pkg::reload_first_off;
  localparam logic [11:0] a_rl2 = timer_regs_pkg::reload_second_off;
  localparam logic [11:0] a_mode = timer_regs_pkg::mode_control_off;
  localparam logic [11:0] a_ictl = timer_regs_pkg::irq_ctl_off;
  localparam logic [11:0] a_clr = timer_regs_pkg::irq_clear_off;

  timer_mode_irq_regs u_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_pin_first(pin1), .timer_pin_second(pin2), .timer_pin_first_out(aout), .timer_pin_first_oe(aoe),
    .first_underflow(ev[0]), .second_underflow(ev[1]), .first_reload_a(ev[2]), .first_reload_b(ev[3]),
    .second_reload_b(ev[4]), .first_counter(c1), .second_counter(c2), .accumulate_mode(acc),
    .first_counter_preset(pre1), .second_counter_preset(pre2), .preset_data(pdata), .accumulate_gate(gate),
    .operating_mode_select(msel), .reload_capture_first(rl1), .reload_capture_second(rl2),
    .timer_irq_first(irq1), .timer_irq_second(irq2));
  far_side_model u_far (.clk(clk), .ev_req(ev_req), .ld(ld), .c1_req(c1_req), .c2_req(c2_req), .pre1(pre1),
    .pre2(pre2), .pdata(pdata), .ev(ev), .c1(c1), .c2(c2));

  // ****************************************
  // Clock, timeout and preset counting
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Presets are pulses, so they are tallied at every edge rather than polled
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (pre1 === 1'b1) n_pre1 <= n_pre1 + 1;
    if (pre2 === 1'b1) n_pre2 <= n_pre2 + 1;
    if (cyc == 5000) begin
      err_count++;
      summarize();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, g, x);
    end
  endtask
  // Request held until pready is seen high at an edge; data taken at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] dd);
    apb(1'b1, a, dd);
    // Let the register update of the access edge settle before outputs are looked at
    @(negedge clk);
    if (a == a_ictl) m = dd[7:0] | (m & 'h0f);
    if (a == a_clr) m = m & ~(dd & 'h0f);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h00000000);
    chk(r, x);
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    ev_req <= 5'h01 << i;
    @(posedge clk);
    ev_req <= 5'h00;
    repeat (3) @(posedge clk);
  endtask
  // Pin edges need sync plus history before they act
  task automatic pin(input int k, input logic v);
    @(posedge clk);
    if (k == 1) pin1 <= v;
    else pin2 <= v;
    repeat (6) @(posedge clk);
  endtask
  task automatic ldc();
    v1 = $urandom & 'hffff;
    v2 = $urandom & 'hffff;
    @(posedge clk);
    c1_req <= v1[15:0];
    c2_req <= v2[15:0];
    ld <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rst_b, psel, penable, pwrite, pin1, pin2, ld, acc} = 8'h00;
    {paddr, pwdata, ev_req, c1_req, c2_req} = 81'h0;
    pstrb = 4'hf;
    {err_count, n_compared, cyc, n_pre1, n_pre2, m} = 192'h0;
    void'($urandom(58037));
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rd(a_mode, 32'h00000000);
    rd(a_ictl, 32'h00000000);
    d = $urandom & 'hffff;
    wr(a_rl1, d);
    rd(a_rl1, d);
    chk(rl1, d);
    wr(a_rl2, ~d & 'hffff);
    rd(a_rl2, ~d & 'hffff);
    apb(1'b0, 12'h020, 32'h00000000);
    chk(e, 1);
    chk(r, 0);
    $display("registers test ended");
    for (int i = 0; i < 4; i++) begin
      wr(a_mode, i);
      chk(msel, i);
    end
    wr(a_mode, 32'hff);
    rd(a_mode, 32'h7f);
    wr(a_mode, 32'h00);
    wr(a_ictl, 32'h0f);
    rd(a_ictl, 32'h0f);
    wr(a_ictl, 32'h00);
    rd(a_ictl, 32'h0f);
    chk({irq1, irq2}, 0);
    for (int i = 0; i < 4; i++) begin
      wr(a_ictl, 32'h10 << i);
      rd(a_ictl, m);
      chk({irq1, irq2}, (i < 3) ? 2 : 1);
    end
    wr(a_clr, 32'h05);
    rd(a_ictl, m);
    wr(a_clr, 32'h0a);
    rd(a_ictl, m);
    rd(a_clr, 32'h00);
    chk(irq2, 0);
    pulse(2);
    m = m | 1;
    rd(a_ictl, m);
    chk(irq1, 0);
    pulse(1);
    m = m | 8;
    chk(irq2, 1);
    $display("interrupt test ended");
    wr(a_mode, 32'h50);
    chk({aoe, aout}, 3);
    pulse(0);
    chk(aout, 0);
    rd(a_mode, 32'h10);
    wr(a_mode, 32'h51);
    chk(aoe, 0);
    wr(a_mode, 32'h40);
    chk(aoe, 0);
    $display("output test ended");
    wr(a_mode, 32'h15);
    ldc();
    pin(1, 1'b1);
    chk(n_pre1, 1);
    chk(pdata, 32'hffff);
    rd(a_rl1, v1);
    m = m | 1;
    rd(a_ictl, m);
    pin(1, 1'b0);
    chk(n_pre1, 1);
    wr(a_mode, 32'h21);
    ldc();
    pin(2, 1'b1);
    chk(n_pre1, 1);
    pin(2, 1'b0);
    chk(n_pre1, 2);
    rd(a_rl2, v1);
    m = m | 2;
    rd(a_ictl, m);
    wr(a_mode, 32'h2b);
    ldc();
    pin(2, 1'b1);
    chk(n_pre2, 1);
    rd(a_rl2, v2);
    chk(rl2, v2);
    wr(a_mode, 32'h28);
    pin(2, 1'b0);
    pin(2, 1'b1);
    chk(n_pre1, 2);
    chk(n_pre2, 1);
    pin(0, 1'b1);
    acc <= 1'b1;
    @(negedge clk);
    chk(gate, 1);
    wr(a_mode, 32'h20);
    chk(gate, 0);
    acc <= 1'b0;
    @(negedge clk);
    chk(gate, 1);
    $display("pin test ended");
    summarize();
  end
endmodule
`default_nettype wire
